// *** hdl/cfl_pkg.sv ***
// Package holding register map, field layout, reset values and loop constants.
package cfl_pkg;
    localparam logic [7:0]  OFS_INTENCLR   = 8'h00;
    localparam logic [7:0]  OFS_INTERRUPT_ENABLE_SET   = 8'h04;
    localparam logic [7:0]  OFS_CLOCK_EVENT_FLAGS    = 8'h08;
    localparam logic [7:0]  OFS_STATUS     = 8'h0C;
    localparam logic [7:0]  OFS_CONTROL    = 8'h10;
    localparam logic [7:0]  OFS_MULT       = 8'h14;
    localparam logic [7:0]  OFS_VALUE      = 8'h18;

    localparam int          BIT_XOSC_RDY   = 0;
    localparam int          BIT_READY      = 4;
    localparam int          BIT_OOB        = 5;
    localparam int          BIT_FINE_LOCK  = 6;
    localparam int          BIT_CRS_LOCK   = 7;
    localparam int          BIT_REF_STOP   = 8;
    localparam int          BIT_LTO        = 17;
    localparam logic [31:0] FLAG_MASK      = 32'h0003_8FFF;
    localparam logic [31:0] FLAG_RESET     = 32'h0000_0000;

    localparam int          CTL_ENABLE     = 0;
    localparam int          CTL_CLOSED     = 1;
    localparam int          CTL_STABLE     = 2;
    localparam logic [2:0]  CTL_RESET      = 3'h0;

    localparam int          MUL_W          = 8;
    localparam logic [7:0]  MUL_RESET      = 8'h20;
    localparam int          MUL_MAX        = 255;
    localparam int          CNT_W          = 10;
    localparam logic [9:0]  CNT_MAX        = 10'h3FF;
    localparam logic [9:0]  REF_STOP_CYCLES = 10'(2 * MUL_MAX);
    localparam int          RATIO_DIFFERENCE_W         = 11;
    localparam int          CRS_W          = 6;
    localparam int          FINE_W         = 10;
    localparam logic [5:0]  CRS_RESET      = 6'h20;
    localparam logic [9:0]  FINE_MID       = 10'h200;
    localparam logic [9:0]  FINE_TOP       = 10'h3FF;
    localparam logic signed [10:0] CRS_TOL  = 11'sd4;
    localparam logic signed [10:0] FINE_TOL = 11'sd0;

    typedef enum logic [1:0] {
        CFL_OFF    = 2'b00,
        CFL_COARSE = 2'b01,
        CFL_FINE   = 2'b10,
        CFL_TRACK  = 2'b11
    } cfl_state_t;
endpackage

// *** hdl/cfl_ratio_meter.sv ***
// Ratio meter counting clock cycles between reference edges and spotting a stopped reference.
module cfl_ratio_meter
    import cfl_pkg::*;
(
    input  wire logic             mclk,
    input  wire logic             arst_n,
    input  wire logic             ref_level,
    output logic                  meas_valid,
    output logic [CNT_W-1:0]      meas_count,
    output logic                  ref_stopped
);
    logic             prev_ref;
    logic             have_edge;
    logic [CNT_W-1:0] cnt;
    logic             rise;
    logic             next_have_edge;
    logic             next_stopped;
    logic             next_valid;
    logic [CNT_W-1:0] next_cnt;
    logic [CNT_W-1:0] next_count;

    always_comb begin
        rise           = ref_level & ~prev_ref;
        next_have_edge = have_edge | rise;
        next_valid     = rise & have_edge & ~ref_stopped;
        next_count     = rise ? cnt : meas_count;
        if (rise) begin
            next_cnt = CNT_W'(1);
        end else if (cnt == CNT_MAX) begin
            next_cnt = cnt;
        end else begin
            next_cnt = cnt + CNT_W'(1);
        end
        if (rise) begin
            next_stopped = 1'b0;
        end else if (cnt >= REF_STOP_CYCLES) begin
            next_stopped = 1'b1;
        end else begin
            next_stopped = ref_stopped;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            prev_ref    <= 1'b0;
            have_edge   <= 1'b0;
            cnt         <= '0;
            meas_valid  <= 1'b0;
            meas_count  <= '0;
            ref_stopped <= 1'b0;
        end else begin
            prev_ref    <= ref_level;
            have_edge   <= next_have_edge;
            cnt         <= next_cnt;
            meas_valid  <= next_valid;
            meas_count  <= next_count;
            ref_stopped <= next_stopped;
        end
    end

    ref_stop_det_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (cnt >= REF_STOP_CYCLES && !rise) |=> ref_stopped)
        else $error("Stopped reference not flagged.");
endmodule

// *** hdl/cfl_top.sv ***
// Closed-loop frequency locker with APB registers, event flags and interrupt.
// What this block does
// - Coarse search first, then coarse-lock bit.
// - Fine trim tuning after coarse, then fine-lock.
// - Lock bits raise interrupt when enabled.
// - Ready bit marks loop clock usable.
// - Store measured ratio minus multiplier as difference.
// - Unstable mode keeps retuning fine, locks kept.
// - Fine trim over or underflow sets out-of-bounds.
// - Slow or stopped reference sets stopped bit.
// - Stopped reference holds trims; resumes on restart.
// - Reference-stopped rising edge requests interrupt.
// - Enable-set writes of one set enables.
// - Crystal ready flag interrupts when enabled.
// - Writing one clears a flag; zero ignored.
// - Lock-timeout flag sets on status rising edge.
// - Fuse-selected flags may be set at startup.
//
// Design decision made here: register access over APB.
module cfl_top
    import cfl_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              arst_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              ref_level,
    input  wire logic              crystal_osc_ready,
    input  wire logic              pll_lock_timeout,
    input  wire logic [7:0]        misc_status,
    input  wire logic [31:0]       fuse_flags,
    output logic [CRS_W-1:0]       coarse_trim,
    output logic [FINE_W-1:0]      fine_trim,
    output logic                   irq
);
    logic [31:0]               interrupt_flags;
    logic [31:0]               interrupt_enable;
    logic [31:0]               prev_status;
    logic                      fuse_done;
    logic [2:0]                loop_control;
    logic [MUL_W-1:0]          multiply_target;
    cfl_state_t                state;
    logic                      coarse_lock_status;
    logic                      fine_lock_status;
    logic                      loop_clock_ready;
    logic                      fine_trim_out_of_bounds;
    logic signed [RATIO_DIFFERENCE_W-1:0]  ratio_difference;
    logic                      meas_valid;
    logic [CNT_W-1:0]          meas_count;
    logic                      reference_stopped;
    logic [31:0]               status_now;
    logic [31:0]               rise;
    wire logic [31:0]          next_flags;
    wire logic [31:0]          next_enable;
    logic [31:0]               next_prdata;
    logic                      addr_ok;
    logic                      wr;
    logic                      next_fuse_done;
    logic [2:0]                next_control;
    logic [MUL_W-1:0]          next_mul;
    cfl_state_t                next_state;
    logic [CRS_W-1:0]          next_coarse;
    logic [FINE_W-1:0]         next_fine;
    logic                      next_clock;
    logic                      next_cl;
    logic                      next_fl;
    logic                      next_oob;
    logic                      next_ready;
    logic signed [RATIO_DIFFERENCE_W-1:0]  next_ratio_difference;
    logic signed [RATIO_DIFFERENCE_W-1:0]  meas_ratio_difference;
    logic                      loop_on;
    logic                      closed_run;

    cfl_ratio_meter u_meter (
        .mclk        (mclk),
        .arst_n      (arst_n),
        .ref_level   (ref_level),
        .meas_valid  (meas_valid),
        .meas_count  (meas_count),
        .ref_stopped (reference_stopped)
    );

    // APB slave with zero wait states; read data is captured in the setup cycle.
    always_comb begin
        pready  = 1'b1;
        addr_ok = (paddr == OFS_INTENCLR) || (paddr == OFS_INTERRUPT_ENABLE_SET) ||
                  (paddr == OFS_CLOCK_EVENT_FLAGS) || (paddr == OFS_STATUS) ||
                  (paddr == OFS_CONTROL) || (paddr == OFS_MULT) || (paddr == OFS_VALUE);
        pslverr = psel & penable & ~addr_ok;
        wr      = psel & penable & pwrite & addr_ok;
        next_prdata = prdata;
        if (psel && !penable && !pwrite) begin
            unique case (paddr)
                OFS_INTENCLR: next_prdata = interrupt_enable;
                OFS_INTERRUPT_ENABLE_SET: next_prdata = interrupt_enable;
                OFS_CLOCK_EVENT_FLAGS:  next_prdata = interrupt_flags & FLAG_MASK;
                OFS_STATUS:   next_prdata = status_now;
                OFS_CONTROL:  next_prdata = {29'h0, loop_control};
                OFS_MULT:     next_prdata = {24'h0, multiply_target};
                OFS_VALUE:    next_prdata = {{(32-RATIO_DIFFERENCE_W-16){ratio_difference[RATIO_DIFFERENCE_W-1]}},
                                             ratio_difference, coarse_trim, fine_trim};
                default:      next_prdata = 32'h0000_0000;
            endcase
        end
    end

    // Status vector feeding the sticky flags.
    always_comb begin
        status_now                = 32'h0000_0000;
        status_now[BIT_XOSC_RDY]  = crystal_osc_ready;
        status_now[3:1]           = misc_status[2:0];
        status_now[BIT_READY]     = loop_clock_ready;
        status_now[BIT_OOB]       = fine_trim_out_of_bounds;
        status_now[BIT_FINE_LOCK] = fine_lock_status;
        status_now[BIT_CRS_LOCK]  = coarse_lock_status;
        status_now[BIT_REF_STOP]  = reference_stopped;
        status_now[11:9]          = misc_status[5:3];
        status_now[16:15]         = misc_status[7:6];
        status_now[BIT_LTO]       = pll_lock_timeout;
        rise                      = status_now & ~prev_status & FLAG_MASK;
        next_fuse_done            = 1'b1;
    end

    // Each flag sets on its status rising edge; a set in the clearing cycle wins.
    genvar g;
    generate
        for (g = 0; g < 32; g++) begin : g_flag
            if (FLAG_MASK[g]) begin : g_used
                assign next_flags[g] = rise[g]
                    | (~fuse_done & fuse_flags[g])
                    | (interrupt_flags[g] & ~(wr && paddr == OFS_CLOCK_EVENT_FLAGS && pwdata[g]));
                assign next_enable[g] =
                    (wr && paddr == OFS_INTERRUPT_ENABLE_SET && pwdata[g]) ? 1'b1 :
                    (wr && paddr == OFS_INTENCLR && pwdata[g]) ? 1'b0 :
                    interrupt_enable[g];
            end else begin : g_rsvd
                assign next_flags[g]  = 1'b0;
                assign next_enable[g] = 1'b0;
            end
        end
    endgenerate

    assign irq = |(interrupt_flags & interrupt_enable);

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            prdata           <= 32'h0000_0000;
            interrupt_flags  <= FLAG_RESET;
            interrupt_enable <= 32'h0000_0000;
            prev_status      <= 32'h0000_0000;
            fuse_done        <= 1'b0;
        end else begin
            prdata           <= next_prdata;
            interrupt_flags  <= next_flags;
            interrupt_enable <= next_enable;
            prev_status      <= status_now;
            fuse_done        <= next_fuse_done;
        end
    end

    // Control registers and the two-stage tuner.
    always_comb begin
        next_control = loop_control;
        next_mul     = multiply_target;
        if (wr && paddr == OFS_CONTROL) begin
            next_control = pwdata[2:0];
        end
        if (wr && paddr == OFS_MULT) begin
            next_mul = pwdata[MUL_W-1:0];
        end
        loop_on    = loop_control[CTL_ENABLE];
        closed_run = loop_on & loop_control[CTL_CLOSED] & ~reference_stopped;
        meas_ratio_difference  = $signed({1'b0, meas_count}) - $signed({3'b000, multiply_target});
        next_state = state;
        next_coarse = coarse_trim;
        next_fine   = fine_trim;
        next_cl     = coarse_lock_status;
        next_fl     = fine_lock_status;
        next_oob    = fine_trim_out_of_bounds;
        next_ready  = loop_on;
        next_ratio_difference   = ratio_difference;
        next_clock  = 1'b0;
        if (!loop_on || !loop_control[CTL_CLOSED]) begin
            next_state = CFL_OFF;
            next_cl    = 1'b0;
            next_fl    = 1'b0;
            next_oob   = 1'b0;
            if (wr && paddr == OFS_VALUE) begin
                next_fine   = pwdata[FINE_W-1:0];
                next_coarse = pwdata[FINE_W+CRS_W-1:FINE_W];
            end
        end else if (closed_run && meas_valid) begin
            next_ratio_difference = meas_ratio_difference;
            unique case (state)
                CFL_OFF: begin
                    next_state = CFL_COARSE;
                end
                CFL_COARSE: begin
                    if (meas_ratio_difference > CRS_TOL) begin
                        next_coarse = coarse_trim - CRS_W'(1);
                    end else if (meas_ratio_difference < -CRS_TOL) begin
                        next_coarse = coarse_trim + CRS_W'(1);
                    end else begin
                        next_cl    = 1'b1;
                        next_fine  = FINE_MID;
                        next_state = CFL_FINE;
                    end
                end
                CFL_FINE, CFL_TRACK: begin
                    next_clock = (state == CFL_FINE) || !loop_control[CTL_STABLE];
                    if (meas_ratio_difference >= -FINE_TOL && meas_ratio_difference <= FINE_TOL) begin
                        next_fl    = 1'b1;
                        next_state = CFL_TRACK;
                    end
                end
            endcase
            if (next_clock && meas_ratio_difference > FINE_TOL) begin
                if (fine_trim == '0) begin
                    next_oob = 1'b1;
                end else begin
                    next_fine = fine_trim - FINE_W'(1);
                end
            end else if (next_clock && meas_ratio_difference < -FINE_TOL) begin
                if (fine_trim == FINE_TOP) begin
                    next_oob = 1'b1;
                end else begin
                    next_fine = fine_trim + FINE_W'(1);
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            loop_control            <= CTL_RESET;
            multiply_target         <= MUL_RESET;
            state                   <= CFL_OFF;
            coarse_trim             <= CRS_RESET;
            fine_trim               <= FINE_MID;
            coarse_lock_status      <= 1'b0;
            fine_lock_status        <= 1'b0;
            fine_trim_out_of_bounds <= 1'b0;
            loop_clock_ready        <= 1'b0;
            ratio_difference        <= '0;
        end else begin
            loop_control            <= next_control;
            multiply_target         <= next_mul;
            state                   <= next_state;
            coarse_trim             <= next_coarse;
            fine_trim               <= next_fine;
            coarse_lock_status      <= next_cl;
            fine_lock_status        <= next_fl;
            fine_trim_out_of_bounds <= next_oob;
            loop_clock_ready        <= next_ready;
            ratio_difference        <= next_ratio_difference;
        end
    end

    fine_after_coarse_a: assert property (@(posedge mclk) disable iff (!arst_n)
        fine_lock_status |-> coarse_lock_status)
        else $error("Fine lock without coarse lock.");

    coarse_lock_set_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (state == CFL_COARSE && closed_run && meas_valid && meas_ratio_difference <= CRS_TOL
         && meas_ratio_difference >= -CRS_TOL) |=> (coarse_lock_status && state == CFL_FINE))
        else $error("Coarse lock not taken.");

    ratio_difference_store_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (closed_run && meas_valid && loop_control[CTL_CLOSED])
        |=> ratio_difference == $past(meas_ratio_difference))
        else $error("Ratio difference not stored.");

    oob_set_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (closed_run && meas_valid && state == CFL_TRACK && !loop_control[CTL_STABLE]
         && ((fine_trim == FINE_TOP && meas_ratio_difference < -FINE_TOL)
             || (fine_trim == '0 && meas_ratio_difference > FINE_TOL))) |=> fine_trim_out_of_bounds)
        else $error("Fine overflow or underflow not flagged.");

    stopped_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (reference_stopped && loop_control[CTL_CLOSED] && !(wr && paddr == OFS_CONTROL))
        |=> $stable(fine_trim) && $stable(coarse_trim))
        else $error("Trims moved while reference stopped.");

    flag_rise_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (fuse_done && pll_lock_timeout && !prev_status[BIT_LTO]) |=> interrupt_flags[BIT_LTO])
        else $error("Lock-timeout flag missed its edge.");

    flag_clear_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (wr && paddr == OFS_CLOCK_EVENT_FLAGS && pwdata[BIT_XOSC_RDY] && !rise[BIT_XOSC_RDY])
        |=> !interrupt_flags[BIT_XOSC_RDY])
        else $error("Write-one did not clear flag.");

    enable_set_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (wr && paddr == OFS_INTERRUPT_ENABLE_SET && pwdata[BIT_XOSC_RDY]) |=> interrupt_enable[BIT_XOSC_RDY])
        else $error("Enable-set write ignored.");

    irq_level_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (interrupt_flags[BIT_REF_STOP] && interrupt_enable[BIT_REF_STOP]) |-> irq)
        else $error("Enabled flag without interrupt.");

    reserved_zero_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (interrupt_flags & ~FLAG_MASK) == 32'h0000_0000)
        else $error("Reserved flag bit set.");
endmodule

// *** sim/cfl_ref_model.sv ***
// Reference clock source model with programmable period and stop control.
module cfl_ref_model (
    input  wire logic        mclk,
    input  wire logic        arst_n,
    input  wire logic        run,
    input  wire logic [15:0] period,
    output logic             ref_level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] cnt;
    // One rising edge per period; the line stands low while stopped.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt       <= 16'h0000;
            ref_level <= 1'b0;
        end else if (!run) begin
            cnt       <= 16'h0000;
            ref_level <= 1'b0;
        end else begin
            cnt       <= (cnt + 16'h0001 >= period) ? 16'h0000 : cnt + 16'h0001;
            ref_level <= (cnt < (period >> 1));
        end
    end
endmodule

// *** sim/cfl_top_test.sv ***
// Self-checking bench for the frequency locker registers, loop and flags.
module cfl_top_test
    import cfl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0, arst_n = 1'b0, run = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00, misc_status = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, fuse_flags = 32'h0000_0000;
    logic        crystal_osc_ready = 1'b0, pll_lock_timeout = 1'b0;
    logic [15:0] period = 16'h0010;
    logic [31:0] prdata, rdat;
    logic        pready, pslverr, ref_level, irq, rerr;
    logic [CRS_W-1:0]  coarse_trim;
    logic [FINE_W-1:0] fine_trim;
    int          n_fail = 0, n_tests = 0, cyc = 0;

    cfl_top dut (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ref_level(ref_level),
        .crystal_osc_ready(crystal_osc_ready), .pll_lock_timeout(pll_lock_timeout),
        .misc_status(misc_status), .fuse_flags(fuse_flags),
        .coarse_trim(coarse_trim), .fine_trim(fine_trim), .irq(irq));
    cfl_ref_model ref_src (.mclk(mclk), .arst_n(arst_n), .run(run), .period(period),
        .ref_level(ref_level));

    initial begin
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_fail++;
            end_sim();
        end
    end

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // One APB transfer; held until pready is sampled high.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic end_sim;
        if (n_fail == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic t_reset;
        chk("trims", 32'({coarse_trim, fine_trim}), 32'({CRS_RESET, FINE_MID}));
        bus(1'b0, OFS_CLOCK_EVENT_FLAGS, 32'h0000_0000);
        chk("flags", rdat, FLAG_RESET);
        bus(1'b0, 8'hFC, 32'h0000_0000);
        chk("unmapped", {rdat[30:0], rerr}, 32'h0000_0001);
    endtask
    task automatic t_flags;
        crystal_osc_ready <= 1'b1;
        misc_status <= 8'h01;
        pll_lock_timeout <= 1'b1;
        bus(1'b0, OFS_CLOCK_EVENT_FLAGS, 32'h0000_0000);
        chk("set", rdat, 32'h0002_0003);
        chk("irq_off", 32'(irq), 32'h0000_0000);
        bus(1'b1, OFS_INTERRUPT_ENABLE_SET, 32'h0000_0001);
        bus(1'b1, OFS_INTERRUPT_ENABLE_SET, 32'h0000_0000);
        bus(1'b0, OFS_INTENCLR, 32'h0000_0000);
        chk("enables", rdat, 32'h0000_0001);
        chk("irq_xosc", 32'(irq), 32'h0000_0001);
        bus(1'b1, OFS_CLOCK_EVENT_FLAGS, 32'h0000_0000);
        bus(1'b1, OFS_CLOCK_EVENT_FLAGS, 32'h0002_0000);
        bus(1'b0, OFS_CLOCK_EVENT_FLAGS, 32'h0000_0000);
        chk("w1c", rdat, 32'h0000_0003);
        bus(1'b1, OFS_CLOCK_EVENT_FLAGS, 32'hFFFF_FFFE);
        bus(1'b0, OFS_CLOCK_EVENT_FLAGS, 32'h0000_0000);
        chk("reserved", rdat, 32'h0000_0001);
        bus(1'b1, OFS_CLOCK_EVENT_FLAGS, 32'h0000_0001);
        wt(1);
        chk("irq_clr", 32'(irq), 32'h0000_0000);
        bus(1'b1, OFS_INTENCLR, 32'hFFFF_FFFF);
    endtask
    task automatic t_lock;
        bus(1'b1, OFS_MULT, 32'h0000_0010);
        bus(1'b1, OFS_INTERRUPT_ENABLE_SET, 32'h0000_00C0);
        period <= 16'h0018;
        run <= 1'b1;
        bus(1'b1, OFS_CONTROL, 32'h0000_0003);
        wt(150);
        chk("coarse_dn", 32'(coarse_trim < CRS_RESET), 32'h0000_0001);
        bus(1'b0, OFS_STATUS, 32'h0000_0000);
        chk("search", rdat & 32'h0000_00D0, 32'h0000_0010);
        period <= 16'h0010;
        wt(150);
        bus(1'b0, OFS_STATUS, 32'h0000_0000);
        chk("locked", rdat & 32'h0000_00D0, 32'h0000_00D0);
        chk("fine_mid", 32'(fine_trim), 32'(FINE_MID));
        chk("irq_lock", 32'(irq), 32'h0000_0001);
        period <= 16'h0011;
        wt(100);
        bus(1'b0, OFS_VALUE, 32'h0000_0000);
        chk("ratio_difference_pos", rdat >> 16, 32'h0000_0001);
        chk("drift", 32'(fine_trim < FINE_MID), 32'h0000_0001);
        bus(1'b0, OFS_STATUS, 32'h0000_0000);
        chk("kept", rdat & 32'h0000_00C0, 32'h0000_00C0);
        period <= 16'h000F;
        wt(100);
        bus(1'b0, OFS_VALUE, 32'h0000_0000);
        chk("ratio_difference_neg", rdat >> 16, 32'h0000_FFFF);
    endtask
    task automatic t_oob;
        period <= 16'h0011;
        wt(10000);
        bus(1'b0, OFS_STATUS, 32'h0000_0000);
        chk("oob", {rdat[5], 21'h0, fine_trim}, 32'h8000_0000);
    endtask
    task automatic t_stop;
        logic [15:0] held;
        bus(1'b1, OFS_CLOCK_EVENT_FLAGS, 32'hFFFF_FFFF);
        bus(1'b1, OFS_INTERRUPT_ENABLE_SET, 32'h0000_0100);
        run <= 1'b0;
        wt(600);
        held = {coarse_trim, fine_trim};
        bus(1'b0, OFS_CLOCK_EVENT_FLAGS, 32'h0000_0000);
        chk("stop", {rdat[8], 30'h0, irq}, 32'h8000_0001);
        wt(100);
        chk("held", 32'({coarse_trim, fine_trim}), 32'(held));
        period <= 16'h000F;
        run <= 1'b1;
        wt(200);
        bus(1'b0, OFS_STATUS, 32'h0000_0000);
        chk("resume", {rdat[8], 30'h0, fine_trim != 10'h000}, 32'h0000_0001);
        bus(1'b1, OFS_CONTROL, 32'h0000_0007);
        wt(1);
        held = {coarse_trim, fine_trim};
        wt(100);
        chk("stable", 32'({coarse_trim, fine_trim}), 32'(held));
        bus(1'b1, OFS_CONTROL, 32'h0000_0001);
        bus(1'b1, OFS_VALUE, 32'h0000_8123);
        wt(1);
        chk("manual", 32'({coarse_trim, fine_trim}), 32'h0000_8123);
    endtask
    task automatic t_fuse;
        fuse_flags <= 32'hFFFF_FFFF;
        arst_n <= 1'b0;
        wt(2);
        arst_n <= 1'b1;
        bus(1'b0, OFS_CLOCK_EVENT_FLAGS, 32'h0000_0000);
        chk("fuse", rdat, FLAG_MASK);
        bus(1'b1, OFS_CLOCK_EVENT_FLAGS, 32'hFFFF_FFFF);
        bus(1'b0, OFS_CLOCK_EVENT_FLAGS, 32'h0000_0000);
        chk("fuse_clr", rdat, 32'h0000_0000);
    endtask

    initial begin
        wt(20);
        arst_n <= 1'b1;
        wt(1);
        t_reset();
        t_flags();
        t_lock();
        t_oob();
        t_stop();
        t_fuse();
        end_sim();
    end
endmodule
